// file: tb/fifo_master_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "slave_fifo_regs.svh"
module fifo_master_model (
    // Link pins toward the port
    output logic o_link_clk,
    output logic o_sel_n,
    output logic o_oe_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic o_pe_n,
    output logic o_sw_n,
    output logic [`ADDR_W-1:0] o_addr,
    output logic [`DATA_W-1:0] o_data
);
    initial begin
        {o_link_clk, o_sel_n, o_oe_n, o_rd_n, o_wr_n, o_pe_n, o_sw_n} = 7'h3f;
        o_addr = 5'h00;
        o_data = 16'h0000;
    end
    // One link period; the clock stands low between calls, pins change while it is low
    task automatic cycle(input logic sel, input logic oe, input logic rd, input logic wr,
                         input logic pe, input logic sw, input logic [`ADDR_W-1:0] a,
                         input logic [`DATA_W-1:0] d);
        o_addr <= a;
        o_sel_n <= !sel;
        o_oe_n <= !oe;
        o_rd_n <= !rd;
        o_wr_n <= !wr;
        o_pe_n <= !pe;
        o_sw_n <= !sw;
        // Released bus shows the inverse so a stale word never passes for data
        o_data <= wr ? d : ~o_data;
        #62.5 o_link_clk <= 1'b1;
        #62.5 o_link_clk <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/sync_slave_fifo_port_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "slave_fifo_regs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module sync_slave_fifo_port_test;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic lclk, sel_n, oe_n, rd_n, wr_n, pe_n, sw_n;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] m_data, o_data, bus;
    logic o_data_oe_n, o_thread_ready, o_short_commit, o_zlp_commit;
    logic [1:0] o_flag, o_commit_thread;
    logic wide = 1'b0;
    logic [3:0] kind = 4'h0;
    logic [3:0] fthr = 4'h0;
    logic [3:0] prod = 4'h0;
    logic [1:0] fen = 2'h0;
    int n_mismatch = 0;
    int check_count = 0;
    int n_short = 0;
    int n_zlp = 0;
    int n;
    always #4 i_clk = ~i_clk;
    // Shared wire level: the port wins while its enable is low
    assign bus = !o_data_oe_n ? o_data : m_data;
    always @(posedge i_clk) begin
        if (o_short_commit === 1'b1) n_short++;
        if (o_zlp_commit === 1'b1) n_zlp++;
    end
    fifo_master_model m (.o_link_clk(lclk), .o_sel_n(sel_n), .o_oe_n(oe_n), .o_rd_n(rd_n),
        .o_wr_n(wr_n), .o_pe_n(pe_n), .o_sw_n(sw_n), .o_addr(addr), .o_data(m_data));
    sync_slave_fifo_port dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_link_clk(lclk),
        .i_port_select_n(sel_n), .i_bus_output_enable_n(oe_n), .i_read_strobe_n(rd_n),
        .i_write_strobe_n(wr_n), .i_packet_commit_n(pe_n), .i_socket_switch_n(sw_n),
        .i_fifo_select_lines(addr), .i_data(bus), .o_data(o_data), .o_data_oe_n(o_data_oe_n),
        .o_flag(o_flag), .o_thread_ready(o_thread_ready), .i_wide_addr(wide),
        .i_flag_kind(kind), .i_flag_fixed_en(fen), .i_flag_fixed_thread(fthr),
        .i_producer(prod), .o_short_commit(o_short_commit), .o_zlp_commit(o_zlp_commit),
        .o_commit_thread(o_commit_thread));
    task automatic idle(input int k, input logic [`ADDR_W-1:0] a);
        repeat (k) m.cycle(1, 0, 0, 0, 0, 0, a, 16'h0000);
    endtask
    task automatic t_write_flags;
        idle(3, 5'h00);
        `CHK(o_flag, 2'h1)
        for (int i = 0; i < 4; i++) m.cycle(1, 0, 0, 1, 0, 0, 5'h00, 16'h1100 + 16'(i));
        idle(2, 5'h00);
        `CHK(o_flag, 2'h0)
        idle(1, 5'h00);
        `CHK(o_flag, 2'h2)
    endtask
    task automatic t_read;
        m.cycle(1, 1, 0, 0, 0, 0, 5'h00, 16'h0000);
        `CHK(o_data_oe_n, 1'b0)
        `CHK(o_data, 16'h1100)
        repeat (3) m.cycle(1, 1, 1, 0, 0, 0, 5'h00, 16'h0000);
        `CHK(o_data, 16'h1101)
        m.cycle(1, 1, 0, 0, 0, 0, 5'h00, 16'h0000);
        `CHK(o_data, 16'h1102)
        idle(1, 5'h00);
        `CHK(o_data_oe_n, 1'b1)
    endtask
    task automatic t_packets;
        repeat (2) m.cycle(0, 0, 0, 1, 1, 0, 5'h01, 16'hdead);
        `CHK(o_flag[0], 1'b0)
        idle(1, 5'h01);
        `CHK(o_flag[0], 1'b1)
        idle(3, 5'h01);
        `CHK(o_flag[0], 1'b1)
        `CHK(n_zlp + n_short, 0)
        m.cycle(1, 0, 0, 0, 1, 0, 5'h01, 16'h0000);
        idle(2, 5'h03);
        `CHK(n_zlp, 1)
        `CHK(o_commit_thread, 2'h1)
        m.cycle(1, 0, 0, 1, 1, 0, 5'h01, 16'h2222);
        idle(2, 5'h03);
        `CHK(n_short, 1)
        `CHK(o_commit_thread, 2'h1)
    endtask
    task automatic t_switch;
        m.cycle(1, 0, 0, 0, 0, 1, 5'h02, 16'h0000);
        `CHK(o_thread_ready, 1'b0)
        n = 1;
        while (o_thread_ready !== 1'b1 && n < `SSD_MAX) begin
            idle(1, 5'h02);
            n++;
        end
        if (n >= `SSD_MAX) begin
            n_mismatch++;
            tally_and_finish();
        end
        `CHK(n >= `SSD_MIN, 1'b1)
        `CHK(o_thread_ready, 1'b1)
        @(posedge i_clk) wide <= 1'b0;
        m.cycle(1, 0, 0, 0, 0, 1, 5'h00, 16'h0000);
        `CHK(o_thread_ready, 1'b1)
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d of %0d checks", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        @(posedge i_clk);
        kind <= 4'h8;
        fen <= 2'h2;
        prod <= 4'h4;
        wide <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (5) @(posedge i_clk);
        t_write_flags();
        t_read();
        t_packets();
        t_switch();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// file: verilog/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Asynchronous level in, synchronised level out
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule
`default_nettype wire

// file: verilog/slave_fifo_pkg.sv
package slave_fifo_pkg;
    typedef enum logic [1:0] {
        SW_IDLE = 2'h0,
        SW_WAIT = 2'h1,
        SW_READY = 2'h3
    } switch_state_t;
endpackage

// file: verilog/slave_fifo_regs.svh
`ifndef SLAVE_FIFO_REGS_SVH
`define SLAVE_FIFO_REGS_SVH
`define DATA_W 16
`define ADDR_W 5
`define THREADS 4
`define FIFO_DEPTH 16
`define PTR_W 4
`define CNT_W 5
`define READ_ACCESS_LATENCY 2
`define WRITE_FLAG_LATENCY 3
`define ADDR_LATENCY 3
`define SSD_MIN 2
`define SSD_MAX 68
`define SSD_DELAY 7'h04
`define FLAG_KIND_EMPTY 2'h0
`define FLAG_KIND_FULL 2'h1
`define FLAG_KIND_PARTIAL 2'h2
`define PARTIAL_LEVEL 5'h04
`endif

// file: verilog/sync_slave_fifo_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "slave_fifo_regs.svh"
module sync_slave_fifo_port (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Link pins
    input wire logic i_link_clk,
    input wire logic i_port_select_n,
    input wire logic i_bus_output_enable_n,
    input wire logic i_read_strobe_n,
    input wire logic i_write_strobe_n,
    input wire logic i_packet_commit_n,
    input wire logic i_socket_switch_n,
    input wire logic [`ADDR_W-1:0] i_fifo_select_lines,
    input wire logic [`DATA_W-1:0] i_data,
    output logic [`DATA_W-1:0] o_data,
    output logic o_data_oe_n,
    output logic [1:0] o_flag,
    output logic o_thread_ready,
    // Configuration straps
    input wire logic i_wide_addr,
    input wire logic [3:0] i_flag_kind,
    input wire logic [1:0] i_flag_fixed_en,
    input wire logic [3:0] i_flag_fixed_thread,
    input wire logic [`THREADS-1:0] i_producer,
    // Packet commit events
    output logic o_short_commit,
    output logic o_zlp_commit,
    output logic [1:0] o_commit_thread
);
    localparam int NIN = 7 + `ADDR_W + `DATA_W;
    logic [NIN-1:0] pins_s;
    logic lclk_s, cs_n_s, oe_n_s, rd_n_s, wr_n_s, pe_n_s, sw_n_s;
    logic [`ADDR_W-1:0] addr_s;
    logic [`DATA_W-1:0] din_s;
    logic lclk_d_r;
    logic edge_w;
    logic [1:0] thr;
    logic [`DATA_W-1:0] mem_r [`THREADS][`FIFO_DEPTH];
    logic [`PTR_W-1:0] rptr_r [`THREADS];
    logic [`PTR_W-1:0] wptr_r [`THREADS];
    logic [`CNT_W-1:0] cnt_r [`THREADS];
    logic rd_go, wr_go;
    logic [`DATA_W-1:0] rdata_d2_r;
    logic [`DATA_W-1:0] rdata_d1_r;
    logic [1:0] flag_d1_r, flag_d2_r;
    slave_fifo_pkg::switch_state_t sw_r;
    logic [6:0] sw_cnt_r;
    logic sw_n_d_r;

    pin_sync #(.W(NIN)) u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_link_clk, i_port_select_n, i_bus_output_enable_n, i_read_strobe_n,
                  i_write_strobe_n, i_packet_commit_n, i_socket_switch_n,
                  i_fifo_select_lines, i_data}),
        .o_sync(pins_s)
    );
    assign {lclk_s, cs_n_s, oe_n_s, rd_n_s, wr_n_s, pe_n_s, sw_n_s, addr_s, din_s} = pins_s;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lclk_d_r <= 1'b0;
        end else begin
            lclk_d_r <= lclk_s;
        end
    end
    assign edge_w = lclk_s & ~lclk_d_r;
    assign thr = addr_s[1:0];

    function automatic logic flag_of(input logic [1:0] kind, input logic [`CNT_W-1:0] c);
        logic f;
        f = 1'b0;
        case (kind)
            `FLAG_KIND_EMPTY: f = (c == '0);
            `FLAG_KIND_FULL: f = (c == `CNT_W'(`FIFO_DEPTH));
            `FLAG_KIND_PARTIAL: f = (c >= `PARTIAL_LEVEL);
            default: f = 1'b0;
        endcase
        return f;
    endfunction

    // Read and write strobes only count while selected
    assign rd_go = edge_w & ~cs_n_s & ~rd_n_s & (cnt_r[thr] != '0);
    assign wr_go = edge_w & ~cs_n_s & ~wr_n_s &
                   (cnt_r[thr] != `CNT_W'(`FIFO_DEPTH));

    genvar g;
    generate
        for (g = 0; g < `THREADS; g++) begin : g_thr
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    rptr_r[g] <= '0;
                    wptr_r[g] <= '0;
                    cnt_r[g] <= '0;
                end else begin
                    if (rd_go && thr == 2'(g)) begin
                        rptr_r[g] <= rptr_r[g] + 1'b1;
                    end
                    if (wr_go && thr == 2'(g)) begin
                        wptr_r[g] <= wptr_r[g] + 1'b1;
                    end
                    cnt_r[g] <= cnt_r[g] + `CNT_W'(wr_go && thr == 2'(g))
                                - `CNT_W'(rd_go && thr == 2'(g));
                end
            end
        end
    endgenerate

    // Storage has no reset; it holds data only
    always_ff @(posedge i_clk) begin
        if (wr_go) begin
            mem_r[thr][wptr_r[thr]] <= din_s;
        end
    end

    // Three-stage link pipeline: a read taken at one edge shows its word two edges later
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_d1_r <= '0;
            rdata_d2_r <= '0;
            o_data <= '0;
        end else if (edge_w) begin
            rdata_d1_r <= mem_r[thr][rd_go ? rptr_r[thr] + 1'b1 : rptr_r[thr]];
            rdata_d2_r <= rdata_d1_r;
            o_data <= rdata_d2_r;
        end
    end
    assign o_data_oe_n = oe_n_s;

    // Flags: kind and source per flag, latency three link edges
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_d1_r <= 2'h0;
            flag_d2_r <= 2'h0;
            o_flag <= 2'h0;
        end else if (edge_w) begin
            for (int k = 0; k < 2; k++) begin
                flag_d1_r[k] <= flag_of(i_flag_kind[2*k +: 2],
                    cnt_r[i_flag_fixed_en[k] ? i_flag_fixed_thread[2*k +: 2] : thr]);
            end
            flag_d2_r <= flag_d1_r;
            o_flag <= flag_d2_r;
        end
    end

    // Packet commits; address assumed stable by master
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_short_commit <= 1'b0;
            o_zlp_commit <= 1'b0;
            o_commit_thread <= 2'h0;
        end else begin
            o_short_commit <= edge_w & ~cs_n_s & ~pe_n_s & ~wr_n_s;
            o_zlp_commit <= edge_w & ~cs_n_s & ~pe_n_s & wr_n_s;
            if (edge_w && !cs_n_s && !pe_n_s) begin
                o_commit_thread <= thr;
            end
        end
    end

    // Socket switching
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sw_r <= slave_fifo_pkg::SW_READY;
            sw_cnt_r <= 7'h00;
            sw_n_d_r <= 1'b1;
        end else if (edge_w) begin
            sw_n_d_r <= sw_n_s;
            case (sw_r)
                slave_fifo_pkg::SW_IDLE: begin
                    sw_r <= slave_fifo_pkg::SW_READY;
                end
                slave_fifo_pkg::SW_WAIT: begin
                    sw_cnt_r <= sw_cnt_r + 7'h01;
                    if (sw_cnt_r >= `SSD_DELAY - 7'h01) begin
                        sw_r <= slave_fifo_pkg::SW_READY;
                    end
                end
                slave_fifo_pkg::SW_READY: begin
                    if (!sw_n_s && sw_n_d_r && i_wide_addr) begin
                        sw_r <= slave_fifo_pkg::SW_WAIT;
                        sw_cnt_r <= 7'h00;
                    end
                end
                default: sw_r <= slave_fifo_pkg::SW_IDLE;
            endcase
        end
    end
    // Producer: room to write; consumer: data to read
    assign o_thread_ready = (sw_r == slave_fifo_pkg::SW_READY) &&
        (i_producer[thr] ? (cnt_r[thr] != `CNT_W'(`FIFO_DEPTH)) : (cnt_r[thr] != '0));

    a_oe_drive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_data_oe_n == oe_n_s) else $error("oe mismatch");
    a_rd_ptr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        rd_go |=> rptr_r[$past(thr)] == $past(rptr_r[thr]) + 1'b1)
        else $error("read pointer stuck");
    a_wr_cnt: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_go && !rd_go |=> cnt_r[$past(thr)] == $past(cnt_r[thr]) + 1'b1)
        else $error("write count stuck");
    a_no_sel: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        cs_n_s |-> (!rd_go && !wr_go) ##1 (!o_zlp_commit && !o_short_commit))
        else $error("strobe when idle");
    a_data_pipe: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        edge_w |=> o_data == $past(rdata_d2_r) && rdata_d2_r == $past(rdata_d1_r))
        else $error("data pipe");
    a_flag_pipe: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        edge_w |=> o_flag == $past(flag_d2_r)) else $error("flag pipe");
    a_zlp_excl: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(o_zlp_commit && o_short_commit)) else $error("both commits");
    a_sw_narrow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_wide_addr && sw_r == slave_fifo_pkg::SW_READY |=> sw_r == slave_fifo_pkg::SW_READY)
        else $error("narrow switch delayed");
    a_sw_bound: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        sw_r == slave_fifo_pkg::SW_WAIT |-> sw_cnt_r < 7'(`SSD_MAX))
        else $error("switch too slow");

    c_read: cover property (@(posedge i_clk) disable iff (!i_rst_n) rd_go ##[1:40] rd_go);
    c_write: cover property (@(posedge i_clk) disable iff (!i_rst_n) wr_go);
    c_zlp: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_zlp_commit);
    c_switch: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        sw_r == slave_fifo_pkg::SW_WAIT ##1 sw_r == slave_fifo_pkg::SW_READY);
endmodule
`default_nettype wire
